/* File: atm_params.svh */
// Constants for the auxiliary scan and threshold monitor.
// Assumes one 25 MHz system clock and 1 MHz-rate source ticks.
`ifndef ATM_PARAMS_SVH
`define ATM_PARAMS_SVH
`define ATM_ADDR_SEL 8'h13
`define ATM_ADDR_DEB 8'h14
`define ATM_ADDR_FLG 8'h15
`define ATM_ADDR_MAXH 8'h16
`define ATM_ADDR_MAXL 8'h17
`define ATM_RST_BYTE 8'h00
`define ATM_SEL_AUX_INPUT_ONE 7
`define ATM_SEL_AUX_INPUT_TWO 6
`define ATM_SEL_VBAT 5
`define ATM_SEL_TEMP 4
`define ATM_SEL_TSEL 3
`define ATM_SEL_A1RES 2
`define ATM_SEL_A2RES 1
`define ATM_SEL_BIAS 0
`define ATM_MAXH_EN 4
`define ATM_DEB_BASE_US 64
`define ATM_SRC_MHZ 1
`define ATM_DEB_TICKS 8
`define ATM_DEB_BASE_SRC (`ATM_DEB_BASE_US * `ATM_SRC_MHZ / `ATM_DEB_TICKS)
`endif

/* File: atm_pkg.sv */
// Types shared by the monitor and its bench.
// Assumes atm_params.svh is on the include path.
package atm_pkg;
    typedef enum logic [2:0] {
        ATM_CH_AUX_INPUT_ONE = 3'h0,
        ATM_CH_AUX_INPUT_TWO = 3'h1,
        ATM_CH_VBAT = 3'h2,
        ATM_CH_TEMPA = 3'h3,
        ATM_CH_TEMPB = 3'h4
    } atm_chan_t;
    typedef struct packed {
        atm_chan_t chan;
        logic res_mode;
        logic bias_ext;
    } atm_cmd_t;
    typedef struct packed {
        logic en;
        logic [11:0] code;
    } atm_thr_t;
    typedef struct packed {
        atm_thr_t aux_input_one_min;
        atm_thr_t aux_input_two_max;
        atm_thr_t aux_input_two_min;
        atm_thr_t temp_max;
        atm_thr_t temp_min;
    } atm_thr_cfg_t;
    typedef enum logic [2:0] {
        ATM_ST_IDLE = 3'b001,
        ATM_ST_PICK = 3'b010,
        ATM_ST_WAIT = 3'b100
    } atm_state_t;
endpackage

/* File: atm_monitor.sv */
// Auxiliary scan sequencer, pen-down debounce and threshold flags.
// Assumes the converter and tick sources share sys_clk_in.
`include "atm_params.svh"
module atm_monitor
    import atm_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic reset_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    output logic reg_rvalid_out,
    input wire logic scan_start_in,
    input wire logic clk_sel_in,
    input wire logic osc_tick_in,
    input wire logic mclk_tick_in,
    input wire logic pen_raw_in,
    input wire atm_thr_cfg_t thr_cfg_in,
    input wire logic conv_done_in,
    input wire atm_chan_t conv_chan_in,
    input wire logic [11:0] conv_result_in,
    output logic conv_req_out,
    output atm_cmd_t conv_cmd_out,
    output logic conv_clk_sel_out,
    output logic scan_busy_out,
    output logic pen_down_out
);
    logic [7:0] sel;
    logic [2:0] deb_code;
    logic [5:0] flags;
    logic [4:0] maxh;
    logic [7:0] maxl;
    logic [3:0] pending;
    atm_state_t state;
    logic pen_meta;
    logic pen_sync;
    logic [9:0] pres;
    logic [2:0] deb_ticks;
    logic src_tick;
    logic rd_flg;
    logic [5:0] next_set;
    logic [11:0] a1_max;

    function automatic logic hit(input logic [11:0] res,
                                 input logic en,
                                 input logic [11:0] thr,
                                 input logic is_max);
        hit = en && (is_max ? (res >= thr) : (res <= thr));
    endfunction

    function automatic logic [9:0] deb_limit(input logic [2:0] code);
        deb_limit = 10'(`ATM_DEB_BASE_SRC) << (code - 3'h1);
    endfunction

    function automatic logic [3:0] first_bit(input logic [3:0] p);
        first_bit = p & (~p + 4'h1);
    endfunction

    assign rd_flg = reg_rd_in && (reg_addr_in == `ATM_ADDR_FLG);
    assign a1_max = {maxh[3:0], maxl};
    // Source clock chosen by the clock-select bit
    assign src_tick = clk_sel_in ? mclk_tick_in : osc_tick_in;

    // Register writes; the flag register ignores writes
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            sel <= `ATM_RST_BYTE;
            deb_code <= 3'h0;
            maxh <= 5'h00;
            maxl <= `ATM_RST_BYTE;
        end
        else if (reg_wr_in)
        begin
            case (reg_addr_in)
                `ATM_ADDR_SEL: sel <= reg_wdata_in;
                `ATM_ADDR_DEB: deb_code <= reg_wdata_in[2:0];
                `ATM_ADDR_MAXH: maxh <= reg_wdata_in[4:0];
                `ATM_ADDR_MAXL: maxl <= reg_wdata_in;
                default: ;
            endcase
        end
    end

    // Read data; reserved bits read zero
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            reg_rdata_out <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end
        else
        begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in)
            begin
                case (reg_addr_in)
                    `ATM_ADDR_SEL: reg_rdata_out <= sel;
                    `ATM_ADDR_DEB: reg_rdata_out <= {5'h00, deb_code};
                    `ATM_ADDR_FLG: reg_rdata_out <= {2'h0, flags};
                    `ATM_ADDR_MAXH: reg_rdata_out <= {3'h0, maxh};
                    `ATM_ADDR_MAXL: reg_rdata_out <= maxl;
                    default: reg_rdata_out <= 8'h00;
                endcase
            end
        end
    end

    // Threshold hits, any completed conversion, scan or not
    always_comb
    begin
        next_set = 6'h00;
        if (conv_done_in)
        begin
            if (conv_chan_in == ATM_CH_AUX_INPUT_ONE)
            begin
                next_set[5] = hit(conv_result_in, maxh[`ATM_MAXH_EN],
                                  a1_max, 1'b1);
                next_set[4] = hit(conv_result_in, thr_cfg_in.aux_input_one_min.en,
                                  thr_cfg_in.aux_input_one_min.code, 1'b0);
            end
            if (conv_chan_in == ATM_CH_AUX_INPUT_TWO)
            begin
                next_set[3] = hit(conv_result_in, thr_cfg_in.aux_input_two_max.en,
                                  thr_cfg_in.aux_input_two_max.code, 1'b1);
                next_set[2] = hit(conv_result_in, thr_cfg_in.aux_input_two_min.en,
                                  thr_cfg_in.aux_input_two_min.code, 1'b0);
            end
            if (conv_chan_in == ATM_CH_TEMPA || conv_chan_in == ATM_CH_TEMPB)
            begin
                next_set[1] = hit(conv_result_in, thr_cfg_in.temp_max.en,
                                  thr_cfg_in.temp_max.code, 1'b1);
                next_set[0] = hit(conv_result_in, thr_cfg_in.temp_min.en,
                                  thr_cfg_in.temp_min.code, 1'b0);
            end
        end
    end

    // Sticky flags; a hit in the read cycle survives the clear
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
            flags <= 6'h00;
        else if (rd_flg)
            flags <= next_set;
        else
            flags <= flags | next_set;
    end

    // Scan sequencer, one conversion at a time
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            state <= ATM_ST_IDLE;
            pending <= 4'h0;
            conv_req_out <= 1'b0;
            conv_cmd_out <= '0;
            scan_busy_out <= 1'b0;
        end
        else
        begin
            conv_req_out <= 1'b0;
            case (state)
                ATM_ST_IDLE:
                begin
                    scan_busy_out <= 1'b0;
                    if (scan_start_in && (|sel[7:4]))
                    begin
                        pending <= sel[7:4];
                        scan_busy_out <= 1'b1;
                        state <= ATM_ST_PICK;
                    end
                end
                ATM_ST_PICK:
                begin
                    if (pending == 4'h0)
                    begin
                        scan_busy_out <= 1'b0;
                        state <= ATM_ST_IDLE;
                    end
                    else
                    begin
                        conv_req_out <= 1'b1;
                        conv_cmd_out.res_mode <= 1'b0;
                        conv_cmd_out.bias_ext <= sel[`ATM_SEL_BIAS];
                        case (first_bit({pending[0], pending[1],
                                         pending[2], pending[3]}))
                            4'h1:
                            begin
                                conv_cmd_out.chan <= ATM_CH_AUX_INPUT_ONE;
                                conv_cmd_out.res_mode <=
                                    sel[`ATM_SEL_A1RES];
                            end
                            4'h2:
                            begin
                                conv_cmd_out.chan <= ATM_CH_AUX_INPUT_TWO;
                                conv_cmd_out.res_mode <=
                                    sel[`ATM_SEL_A2RES];
                            end
                            4'h4: conv_cmd_out.chan <= ATM_CH_VBAT;
                            default:
                                conv_cmd_out.chan <= sel[`ATM_SEL_TSEL] ?
                                    ATM_CH_TEMPB : ATM_CH_TEMPA;
                        endcase
                        state <= ATM_ST_WAIT;
                    end
                end
                ATM_ST_WAIT:
                begin
                    if (conv_done_in)
                        state <= ATM_ST_PICK;
                end
                default: state <= ATM_ST_IDLE;
            endcase
            if (state == ATM_ST_PICK && pending != 4'h0)
            begin
                // Drop the channel just issued, highest bit first
                if (pending[3])
                    pending[3] <= 1'b0;
                else if (pending[2])
                    pending[2] <= 1'b0;
                else if (pending[1])
                    pending[1] <= 1'b0;
                else
                    pending[0] <= 1'b0;
            end
        end
    end

    // Converter clock source follows the select bit
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
            conv_clk_sel_out <= 1'b0;
        else
            conv_clk_sel_out <= clk_sel_in;
    end

    // Pen pin synchroniser
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            pen_meta <= 1'b0;
            pen_sync <= 1'b0;
        end
        else
        begin
            pen_meta <= pen_raw_in;
            pen_sync <= pen_meta;
        end
    end

    // Debounce: eight timer ticks, each duration/8 source ticks.
    // Any release restarts the whole interval.
    always_ff @(posedge sys_clk_in)
    begin
        if (reset_in)
        begin
            pres <= 10'h000;
            deb_ticks <= 3'h0;
            pen_down_out <= 1'b0;
        end
        else if (!pen_sync)
        begin
            pres <= 10'h000;
            deb_ticks <= 3'h0;
            pen_down_out <= 1'b0;
        end
        else if (deb_code == 3'h0)
            pen_down_out <= 1'b1;
        else if (!pen_down_out && src_tick)
        begin
            if (pres == deb_limit(deb_code) - 10'h001)
            begin
                pres <= 10'h000;
                deb_ticks <= deb_ticks + 3'h1;
                if (deb_ticks == 3'(`ATM_DEB_TICKS - 1))
                    pen_down_out <= 1'b1;
            end
            else
                pres <= pres + 10'h001;
        end
    end

    default clocking atm_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);

    a_aux_input_one_gate: assert property (conv_req_out && conv_cmd_out.chan ==
        ATM_CH_AUX_INPUT_ONE |-> $past(sel[`ATM_SEL_AUX_INPUT_ONE], 2))
        else $error("aux one converted while disabled");
    a_aux_input_two_gate: assert property (conv_req_out && conv_cmd_out.chan ==
        ATM_CH_AUX_INPUT_TWO |-> $past(sel[`ATM_SEL_AUX_INPUT_TWO], 2))
        else $error("aux two converted while disabled");
    a_vbat_gate: assert property (conv_req_out && conv_cmd_out.chan ==
        ATM_CH_VBAT |-> $past(sel[`ATM_SEL_VBAT], 2))
        else $error("battery converted while disabled");
    a_temp_pick: assert property (conv_req_out &&
        conv_cmd_out.chan inside {ATM_CH_TEMPA, ATM_CH_TEMPB} |->
        (conv_cmd_out.chan == ATM_CH_TEMPB) == $past(sel[`ATM_SEL_TSEL]))
        else $error("wrong temperature sensor");
    a_aux_input_one_mode: assert property (conv_req_out && conv_cmd_out.chan ==
        ATM_CH_AUX_INPUT_ONE |-> conv_cmd_out.res_mode == $past(sel[`ATM_SEL_A1RES]))
        else $error("aux one mode mismatch");
    a_bias_mode: assert property (conv_req_out |->
        conv_cmd_out.bias_ext == $past(sel[`ATM_SEL_BIAS]))
        else $error("bias mode mismatch");
    a_req_single: assert property (conv_req_out |=> !conv_req_out [*2])
        else $error("request longer than one cycle");
    a_max_flag: assert property (conv_done_in &&
        conv_chan_in == ATM_CH_AUX_INPUT_ONE && maxh[`ATM_MAXH_EN] &&
        conv_result_in >= a1_max |=> flags[5])
        else $error("aux one max flag missed");
    a_max_off: assert property (conv_done_in &&
        conv_chan_in == ATM_CH_AUX_INPUT_ONE && !maxh[`ATM_MAXH_EN] && !flags[5]
        && !$past(flags[5]) |=> !flags[5])
        else $error("aux one max flag while disabled");
    a_read_clear: assert property (rd_flg && !conv_done_in |=>
        flags == 6'h00 && reg_rdata_out[5:0] == $past(flags))
        else $error("flag read did not clear");
    a_deb_span: assert property ($rose(pen_down_out) &&
        deb_code != 3'h0 |-> $past(deb_ticks) == 3'h7 && pen_sync)
        else $error("pen down before debounce ended");

    c_full_scan: cover property (scan_start_in && sel[7:4] == 4'hf
        && state == ATM_ST_IDLE);
    c_flag_set: cover property (conv_done_in && next_set != 6'h00);
    c_read_race: cover property (rd_flg && next_set != 6'h00);
    c_pen_long: cover property ($rose(pen_down_out) && deb_code == 3'h7);
endmodule

/* File: atm_conv_model.sv */
// Converter-side model: answers each request after a set delay.
// Assumes one request at a time and a host-style inject for non-scan reads.
module atm_conv_model
    import atm_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic req_in,
    input wire atm_cmd_t cmd_in,
    input wire logic [3:0] delay_in,
    input wire logic inject_in,
    input wire atm_chan_t inject_chan_in,
    input wire logic [11:0] result_in,
    output logic done_out,
    output atm_chan_t chan_out,
    output logic [11:0] result_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic busy;
    logic [3:0] wait_cnt;
    atm_chan_t pend_chan;

    always_ff @(posedge clk_in)
    begin
        done_out <= 1'b0;
        // Result toggles outside done so a stale value never looks valid
        result_out <= ~result_out;
        if (reset_in)
        begin
            busy <= 1'b0;
            wait_cnt <= 4'h0;
            result_out <= 12'h000;
        end
        else if (req_in)
        begin
            busy <= 1'b1;
            wait_cnt <= delay_in;
            pend_chan <= cmd_in.chan;
        end
        else if (busy && wait_cnt != 4'h0)
            wait_cnt <= wait_cnt - 4'h1;
        else if (busy || inject_in)
        begin
            busy <= 1'b0;
            done_out <= 1'b1;
            chan_out <= busy ? pend_chan : inject_chan_in;
            result_out <= result_in;
        end
    end
endmodule

/* File: atm_monitor_test.sv */
// Self-checking bench for the auxiliary scan and threshold monitor.
// Assumes atm_pkg and atm_conv_model are compiled before this file.
module atm_monitor_test
    import atm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] reg_addr_in = 8'h00;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic scan_start_in = 1'b0;
    logic clk_sel_in = 1'b0;
    logic osc_tick_in = 1'b0;
    logic mclk_tick_in = 1'b0;
    logic pen_raw_in = 1'b0;
    atm_thr_cfg_t thr_cfg_in = '0;
    logic [3:0] delay = 4'h0;
    logic inject = 1'b0;
    atm_chan_t inj_chan = ATM_CH_AUX_INPUT_ONE;
    logic [11:0] res_val = 12'h000;
    logic [7:0] reg_rdata_out;
    logic reg_rvalid_out, conv_done_in, conv_req_out, conv_clk_sel_out;
    logic scan_busy_out, pen_down_out;
    atm_chan_t conv_chan_in;
    logic [11:0] conv_result_in;
    atm_cmd_t conv_cmd_out;
    atm_cmd_t log_q[$];
    int num_errors = 0;
    int n_checks = 0;

    atm_monitor i_atm_monitor (.sys_clk_in, .reset_in, .reg_addr_in,
        .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
        .reg_rvalid_out, .scan_start_in, .clk_sel_in, .osc_tick_in,
        .mclk_tick_in, .pen_raw_in, .thr_cfg_in, .conv_done_in,
        .conv_chan_in, .conv_result_in, .conv_req_out, .conv_cmd_out,
        .conv_clk_sel_out, .scan_busy_out, .pen_down_out);

    atm_conv_model i_atm_conv_model (.clk_in(sys_clk_in), .reset_in,
        .req_in(conv_req_out), .cmd_in(conv_cmd_out), .delay_in(delay),
        .inject_in(inject), .inject_chan_in(inj_chan),
        .result_in(res_val), .done_out(conv_done_in),
        .chan_out(conv_chan_in), .result_out(conv_result_in));

    always #20 sys_clk_in = ~sys_clk_in;

    // Log every issued command for order checks
    always @(posedge sys_clk_in)
        if (conv_req_out === 1'b1)
            log_q.push_back(conv_cmd_out);

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge sys_clk_in);
        reg_wr_in = 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk_in);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(negedge sys_clk_in);
        reg_rd_in = 1'b0;
        chk("rvalid", 16'h0001, 16'(reg_rvalid_out));
        chk("rdata", 16'(exp), 16'(reg_rdata_out));
    endtask

    task automatic end_sim;
        $display("Checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic t_regs;
        for (int a = 8'h13; a <= 8'h17; a++)
            rd_chk(8'(a), 8'h00);
        rd_chk(8'h20, 8'h00);
        reg_wr(8'h13, 8'ha5);
        rd_chk(8'h13, 8'ha5);
        reg_wr(8'h14, 8'hff);
        rd_chk(8'h14, 8'h07);
        reg_wr(8'h16, 8'hff);
        rd_chk(8'h16, 8'h1f);
        reg_wr(8'h17, 8'h5a);
        rd_chk(8'h17, 8'h5a);
        reg_wr(8'h15, 8'h3f);
        rd_chk(8'h15, 8'h00);
    endtask

    task automatic do_scan(input logic [7:0] sel, input logic [3:0] d);
        reg_wr(8'h13, sel);
        delay = d;
        log_q.delete();
        @(negedge sys_clk_in);
        scan_start_in = 1'b1;
        @(negedge sys_clk_in);
        scan_start_in = 1'b0;
        repeat (2) @(negedge sys_clk_in);
        chk("busy_on", 16'(|sel[7:4]), 16'(scan_busy_out));
        // A start while busy must be ignored
        scan_start_in = 1'b1;
        @(negedge sys_clk_in);
        scan_start_in = 1'b0;
        for (int i = 0; i < 300 && scan_busy_out !== 1'b0; i++)
            @(negedge sys_clk_in);
        chk("busy", 16'h0000, 16'(scan_busy_out));
    endtask

    task automatic t_scan_all;
        do_scan(8'hff, 4'h0);
        chk("count", 16'h0004, 16'(log_q.size()));
        chk("cmd0", 16'({ATM_CH_AUX_INPUT_ONE, 2'b11}), 16'(log_q[0]));
        chk("cmd1", 16'({ATM_CH_AUX_INPUT_TWO, 2'b11}), 16'(log_q[1]));
        chk("cmd2", 16'(ATM_CH_VBAT), 16'(log_q[2].chan));
        chk("cmd3", 16'(ATM_CH_TEMPB), 16'(log_q[3].chan));
    endtask

    task automatic t_scan_part;
        do_scan(8'h52, 4'h9);
        chk("count", 16'h0002, 16'(log_q.size()));
        chk("cmd0", 16'({ATM_CH_AUX_INPUT_TWO, 2'b10}), 16'(log_q[0]));
        chk("cmd1", 16'(ATM_CH_TEMPA), 16'(log_q[1].chan));
        do_scan(8'h00, 4'h0);
        chk("count", 16'h0000, 16'(log_q.size()));
    endtask

    task automatic inj(input atm_chan_t c, input logic [11:0] v);
        @(negedge sys_clk_in);
        inj_chan = c;
        res_val = v;
        inject = 1'b1;
        @(negedge sys_clk_in);
        inject = 1'b0;
        repeat (2) @(negedge sys_clk_in);
    endtask

    task automatic t_flags;
        thr_cfg_in = '{aux_input_one_min: '{1'b1, 12'h100}, aux_input_two_max: '{1'b1, 12'h800},
            aux_input_two_min: '{1'b1, 12'h200}, temp_max: '{1'b1, 12'h700},
            temp_min: '{1'b1, 12'h300}};
        rd_chk(8'h15, 8'h00);
        reg_wr(8'h16, 8'h1a);
        reg_wr(8'h17, 8'h34);
        inj(ATM_CH_AUX_INPUT_ONE, 12'ha34);
        rd_chk(8'h15, 8'h20);
        rd_chk(8'h15, 8'h00);
        inj(ATM_CH_AUX_INPUT_ONE, 12'ha33);
        rd_chk(8'h15, 8'h00);
        inj(ATM_CH_AUX_INPUT_ONE, 12'h100);
        inj(ATM_CH_AUX_INPUT_TWO, 12'h800);
        inj(ATM_CH_AUX_INPUT_TWO, 12'h200);
        inj(ATM_CH_TEMPB, 12'h700);
        inj(ATM_CH_TEMPA, 12'h300);
        rd_chk(8'h15, 8'h1f);
        // Hit and flag read at one edge: the hit must survive
        @(negedge sys_clk_in);
        inj_chan = ATM_CH_AUX_INPUT_ONE;
        res_val = 12'h0ff;
        inject = 1'b1;
        @(negedge sys_clk_in);
        inject = 1'b0;
        reg_addr_in = 8'h15;
        reg_rd_in = 1'b1;
        @(negedge sys_clk_in);
        reg_rd_in = 1'b0;
        chk("race_rdata", 16'h0000, 16'(reg_rdata_out));
        rd_chk(8'h15, 8'h10);
        reg_wr(8'h16, 8'h0f);
        inj(ATM_CH_AUX_INPUT_ONE, 12'hfff);
        rd_chk(8'h15, 8'h00);
    endtask

    task automatic t_debounce;
        int exp;
        for (int k = 0; k < 8; k++)
        begin
            // Two edges of sync before counting starts; pen rises on the last count edge
            exp = (k == 0) ? 1 : 8 * (8 << (k - 1));
            clk_sel_in = k[0];
            osc_tick_in = !k[0];
            mclk_tick_in = k[0];
            reg_wr(8'h14, 8'(k));
            pen_raw_in = 1'b1;
            repeat (exp + 1) @(negedge sys_clk_in);
            chk("early", 16'h0000, 16'(pen_down_out));
            @(negedge sys_clk_in);
            chk("pen", 16'h0001, 16'(pen_down_out));
            chk("clksel", 16'(k[0]), 16'(conv_clk_sel_out));
            pen_raw_in = 1'b0;
            repeat (6) @(negedge sys_clk_in);
            chk("release", 16'h0000, 16'(pen_down_out));
        end
    endtask

    initial
    begin
        repeat (2) @(negedge sys_clk_in);
        reset_in = 1'b0;
        t_regs();
        t_scan_all();
        t_scan_part();
        t_flags();
        t_debounce();
        end_sim();
    end

    // Whole run is near 8400 cycles; allow over three times that
    initial
    begin
        #(40 * 30000);
        num_errors++;
        end_sim();
    end
endmodule
